// ==== verilog/rsc_reset_source_controller.sv ====
// Reset source controller: qualifies the reset pad and a selectable GPIO
// into power-on and hardware resets, adds CPU software resets, with its registers on AXI4-Lite.
// Assumes rst_n is the internal supply-driven power-on reset and that
// cpu_reset_request and wake_from_sleep are mclk-synchronous pulses.
`timescale 1ns/10ps
module rsc_reset_source_controller
  import rsc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  reset_pad,
  input  wire logic [GPIO_COUNT-1:0] gpio_in,
  input  wire logic                  rc_clk_in,
  input  wire logic                  cpu_reset_request,
  input  wire logic                  wake_from_sleep,
  output logic                       por_reset,
  output logic                       hw_reset,
  output logic                       soft_reset_bit,
  output logic                       cold_start,
  output logic                       rc_osc_enable,
  output logic                       rc_default_trim,
  output logic [7:0]                 reference_trim,
  output logic [7:0]                 crystal_trim,
  output logic [1:0]                 exchange_memory_map,
  output logic                       debug_freeze_enable
);

  // Input synchronisation.
  logic [GPIO_COUNT+1:0] sync_in;
  logic [GPIO_COUNT-1:0] gpio_sync;
  logic                  pad_sync;
  logic                  rc_sync;

  // The GPIO is only sampled here, so its normal pad function is untouched.
  rsc_sync2 #(.WIDTH(GPIO_COUNT + 2)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({rc_clk_in, reset_pad, gpio_in}),
    .sync_out (sync_in)
  );

  assign gpio_sync = sync_in[GPIO_COUNT-1:0];
  assign pad_sync  = sync_in[GPIO_COUNT];
  assign rc_sync   = sync_in[GPIO_COUNT+1];

  // Register file state.
  logic                  soft_pulse_reg,  soft_pulse_next;
  logic                  wake_arm_reg,    wake_arm_next;
  logic                  rc_enable_reg,   rc_enable_next;
  logic [PIN_SEL_W-1:0]  pin_select_reg,  pin_select_next;
  logic                  polarity_reg,    polarity_next;
  logic [POR_TIME_W-1:0] por_time_reg,    por_time_next;
  logic [7:0]            ref_trim_reg,    ref_trim_next;
  logic [7:0]            xtal_trim_reg,   xtal_trim_next;
  logic [1:0]            emap_reg,        emap_next;
  logic                  freeze_reg,      freeze_next;
  logic [31:0]           scratch_reg,     scratch_next;
  logic [2:0]            cause_reg,       cause_next;

  // Source qualification.
  logic gpio_active;
  logic pad_active;
  logic any_source;
  logic rc_prev_reg;
  logic rc_tick;

  assign pad_active  = pad_sync;
  assign gpio_active = (pin_select_reg != '0) &&
                       (gpio_sync[pin_select_reg] == polarity_reg);
  assign any_source  = pad_active | gpio_active;
  assign rc_tick     = rc_sync & ~rc_prev_reg;

  // Power-on timer group.
  rsc_timer_state_type   tmr_state_reg, tmr_state_next;
  logic [PRESCALE_W-1:0] prescale_reg,  prescale_next;
  logic [POR_TIME_W-1:0] unit_cnt_reg,  unit_cnt_next;
  logic                  pad_seen_reg,  pad_seen_next;
  logic                  por_evt;
  logic                  pad_short_evt;

  always_comb begin
    tmr_state_next = tmr_state_reg;
    prescale_next  = prescale_reg;
    unit_cnt_next  = unit_cnt_reg;
    pad_seen_next  = pad_seen_reg;
    por_evt        = 1'b0;
    pad_short_evt  = 1'b0;
    unique case (tmr_state_reg)
      TMR_IDLE: begin
        if (any_source) begin
          tmr_state_next = TMR_COUNT;
          pad_seen_next  = pad_active;
        end
      end
      TMR_COUNT: begin
        if (!any_source) begin
          // A pad pulse shorter than the delay becomes a hardware reset.
          tmr_state_next = TMR_IDLE;
          prescale_next  = '0;
          unit_cnt_next  = '0;
          pad_seen_next  = 1'b0;
          pad_short_evt  = pad_seen_reg;
        end else if (unit_cnt_reg >= por_time_reg) begin
          tmr_state_next = TMR_FIRED;
          por_evt        = 1'b1;
        end else begin
          // One source may hand over to the other without restarting.
          pad_seen_next = pad_seen_reg | pad_active;
          if (rc_tick) begin
            prescale_next = prescale_reg + 12'h001;
            if (prescale_reg == PRESCALE_LAST) begin
              unit_cnt_next = unit_cnt_reg + 7'h01;
            end
          end
        end
      end
      TMR_FIRED: begin
        // Hold here until released so one long assertion fires only once.
        if (!any_source) begin
          tmr_state_next = TMR_IDLE;
          prescale_next  = '0;
          unit_cnt_next  = '0;
          pad_seen_next  = 1'b0;
        end
      end
      default: begin
        tmr_state_next = TMR_IDLE;
        prescale_next  = '0;
        unit_cnt_next  = '0;
        pad_seen_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_state_reg <= TMR_IDLE;
      prescale_reg  <= '0;
      unit_cnt_reg  <= '0;
      pad_seen_reg  <= 1'b0;
      rc_prev_reg   <= 1'b0;
    end else begin
      tmr_state_reg <= tmr_state_next;
      prescale_reg  <= prescale_next;
      unit_cnt_reg  <= unit_cnt_next;
      pad_seen_reg  <= pad_seen_next;
      rc_prev_reg   <= rc_sync;
    end
  end

  // Reset event classification.
  logic hw_evt;
  logic sw_evt;

  assign hw_evt = pad_short_evt | (wake_from_sleep & wake_arm_reg);
  assign sw_evt = cpu_reset_request | soft_pulse_reg;

  // Reset output group.
  logic [HOLD_W-1:0] hold_reg,  hold_next;
  logic              por_reg,   por_next;
  logic              hw_reg,    hw_next;
  logic              sw_reg,    sw_next;
  logic              rcen_reg,  rcen_next;
  logic              dtrim_reg, dtrim_next;

  always_comb begin
    hold_next = hold_reg;
    por_next  = por_reg;
    hw_next   = hw_reg;
    sw_next   = sw_reg;
    if (por_evt | hw_evt | sw_evt) begin
      // A new event restarts the pulse and adds its class to any in progress.
      hold_next = RESET_HOLD_CYCLES;
      por_next  = por_reg | por_evt;
      hw_next   = hw_reg | hw_evt;
      sw_next   = sw_reg | sw_evt;
    end else if (hold_reg != '0) begin
      hold_next = hold_reg - 5'h01;
    end else begin
      por_next = 1'b0;
      hw_next  = 1'b0;
      sw_next  = 1'b0;
    end
    rcen_next  = rc_enable_reg | any_source;
    dtrim_next = pad_active;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg  <= '0;
      por_reg   <= 1'b0;
      hw_reg    <= 1'b0;
      sw_reg    <= 1'b0;
      rcen_reg  <= 1'b0;
      dtrim_reg <= 1'b0;
    end else begin
      hold_reg  <= hold_next;
      por_reg   <= por_next;
      hw_reg    <= hw_next;
      sw_reg    <= sw_next;
      rcen_reg  <= rcen_next;
      dtrim_reg <= dtrim_next;
    end
  end

  assign por_reset           = por_reg;
  assign hw_reset            = hw_reg;
  assign soft_reset_bit            = sw_reg;
  assign cold_start          = por_reg | hw_reg;
  assign rc_osc_enable       = rcen_reg;
  assign rc_default_trim     = dtrim_reg;
  assign reference_trim      = ref_trim_reg;
  assign crystal_trim        = xtal_trim_reg;
  assign exchange_memory_map = emap_reg;
  assign debug_freeze_enable = freeze_reg;

  // AXI4-Lite bus group.
  logic        aw_full_reg, aw_full_next;
  logic [7:0]  awaddr_reg,  awaddr_next;
  logic        w_full_reg,  w_full_next;
  logic [31:0] wdata_reg,   wdata_next;
  logic [3:0]  wstrb_reg,   wstrb_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;
  logic        wr_en;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_en         = aw_full_reg && w_full_reg && !bvalid_reg;

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_SYS_CTRL:  rd_word = 32'h00000000;
      ADDR_PWR_CTRL: begin
        rd_word[RESET_AT_WAKE_POS] = wake_arm_reg;
        rd_word[RC_ENABLE_POS]     = rc_enable_reg;
      end
      ADDR_POR_PIN: begin
        rd_word[PIN_SELECT_LSB +: PIN_SEL_W] = pin_select_reg;
        rd_word[POLARITY_POS]                = polarity_reg;
      end
      ADDR_POR_TIMER: rd_word[POR_TIME_LSB +: POR_TIME_W] = por_time_reg;
      ADDR_REF_TRIM:  rd_word[7:0] = ref_trim_reg;
      ADDR_XTAL_TRIM: rd_word[7:0] = xtal_trim_reg;
      ADDR_GEN_CTRL: begin
        rd_word[EMAP_LSB +: 2] = emap_reg;
        rd_word[FREEZE_POS]    = freeze_reg;
      end
      ADDR_STATUS: begin
        rd_word[CAUSE_LSB +: 3]                  = cause_reg;
        rd_word[SRC_ACTIVE_POS]                  = any_source;
        rd_word[RC_RUN_POS]                      = rcen_reg;
        rd_word[UNIT_COUNT_LSB +: POR_TIME_W]    = unit_cnt_reg;
      end
      ADDR_SCRATCH:   rd_word = scratch_reg;
      default:        rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    aw_full_next = aw_full_reg;
    awaddr_next  = awaddr_reg;
    w_full_next  = w_full_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (wr_en) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (awaddr_reg <= ADDR_SCRATCH && awaddr_reg[1:0] == 2'h0) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_full_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      awaddr_reg  <= awaddr_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Register file group: writes first, then reset-class clears, then cause sets.
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic        por_grp;
  logic        hw_grp;

  assign wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wbits   = wdata_reg & wmask;
  assign por_grp = por_evt;
  assign hw_grp  = por_evt | hw_evt;

  always_comb begin
    soft_pulse_next = 1'b0;
    wake_arm_next   = wake_arm_reg;
    rc_enable_next  = rc_enable_reg;
    pin_select_next = pin_select_reg;
    polarity_next   = polarity_reg;
    por_time_next   = por_time_reg;
    ref_trim_next   = ref_trim_reg;
    xtal_trim_next  = xtal_trim_reg;
    emap_next       = emap_reg;
    freeze_next     = freeze_reg;
    scratch_next    = scratch_reg;
    cause_next      = cause_reg;
    if (wr_en) begin
      unique case (awaddr_reg)
        ADDR_SYS_CTRL:  soft_pulse_next = wbits[SOFT_RESET_POS];
        ADDR_PWR_CTRL: begin
          if (wstrb_reg[0]) begin
            wake_arm_next  = wdata_reg[RESET_AT_WAKE_POS];
            rc_enable_next = wdata_reg[RC_ENABLE_POS];
          end
        end
        ADDR_POR_PIN: begin
          if (wstrb_reg[0]) pin_select_next = wdata_reg[PIN_SELECT_LSB +: PIN_SEL_W];
          if (wstrb_reg[1]) polarity_next = wdata_reg[POLARITY_POS];
        end
        ADDR_POR_TIMER: begin
          if (wstrb_reg[0]) por_time_next = wdata_reg[POR_TIME_LSB +: POR_TIME_W];
        end
        ADDR_REF_TRIM:  if (wstrb_reg[0]) ref_trim_next = wdata_reg[7:0];
        ADDR_XTAL_TRIM: if (wstrb_reg[0]) xtal_trim_next = wdata_reg[7:0];
        ADDR_GEN_CTRL: begin
          if (wstrb_reg[0]) begin
            emap_next   = wdata_reg[EMAP_LSB +: 2];
            freeze_next = wdata_reg[FREEZE_POS];
          end
        end
        ADDR_STATUS:    cause_next = cause_reg & ~wbits[CAUSE_LSB +: 3];
        ADDR_SCRATCH:   scratch_next = (scratch_reg & ~wmask) | wbits;
        default: begin
        end
      endcase
    end
    if (por_evt | hw_evt | sw_evt) begin
      pin_select_next = '0;
      scratch_next    = SCRATCH_RST;
    end
    if (hw_grp) begin
      soft_pulse_next = 1'b0;
      wake_arm_next   = 1'b0;
      rc_enable_next  = 1'b0;
      xtal_trim_next  = XTAL_TRIM_RST;
      emap_next       = 2'h0;
      freeze_next     = 1'b0;
    end
    if (por_grp) begin
      polarity_next = 1'b0;
      por_time_next = POR_TIME_RST;
      ref_trim_next = REF_TRIM_RST;
      cause_next    = 3'h0;
    end
    // Hardware sets win over a software clear in the same cycle.
    cause_next = cause_next | {sw_evt, hw_evt, por_evt};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_pulse_reg <= 1'b0;
      wake_arm_reg   <= 1'b0;
      rc_enable_reg  <= 1'b0;
      pin_select_reg <= '0;
      polarity_reg   <= 1'b0;
      por_time_reg   <= POR_TIME_RST;
      ref_trim_reg   <= REF_TRIM_RST;
      xtal_trim_reg  <= XTAL_TRIM_RST;
      emap_reg       <= 2'h0;
      freeze_reg     <= 1'b0;
      scratch_reg    <= SCRATCH_RST;
      cause_reg      <= 3'h0;
    end else begin
      soft_pulse_reg <= soft_pulse_next;
      wake_arm_reg   <= wake_arm_next;
      rc_enable_reg  <= rc_enable_next;
      pin_select_reg <= pin_select_next;
      polarity_reg   <= polarity_next;
      por_time_reg   <= por_time_next;
      ref_trim_reg   <= ref_trim_next;
      xtal_trim_reg  <= xtal_trim_next;
      emap_reg       <= emap_next;
      freeze_reg     <= freeze_next;
      scratch_reg    <= scratch_next;
      cause_reg      <= cause_next;
    end
  end

endmodule // rsc_reset_source_controller

// ==== inc/rsc_pkg.sv ====
// Constants for the reset source controller: register map, field layout,
// reset values, enumerations and cycle counts.
// Assumes a 10 MHz mclk and a 32 kHz RC clock that arrives as an asynchronous pin.
package rsc_pkg;

  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_SYS_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PWR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_POR_PIN    = 8'h08;
  localparam logic [7:0] ADDR_POR_TIMER  = 8'h0C;
  localparam logic [7:0] ADDR_REF_TRIM   = 8'h10;
  localparam logic [7:0] ADDR_XTAL_TRIM  = 8'h14;
  localparam logic [7:0] ADDR_GEN_CTRL   = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1C;
  localparam logic [7:0] ADDR_SCRATCH    = 8'h20;

  // Field positions.
  localparam int SOFT_RESET_POS    = 0;
  localparam int RESET_AT_WAKE_POS = 0;
  localparam int RC_ENABLE_POS     = 1;
  localparam int PIN_SELECT_LSB    = 0;
  localparam int POLARITY_POS      = 8;
  localparam int POR_TIME_LSB      = 0;
  localparam int EMAP_LSB          = 0;
  localparam int FREEZE_POS        = 4;
  localparam int CAUSE_LSB         = 0;
  localparam int SRC_ACTIVE_POS    = 3;
  localparam int RC_RUN_POS        = 4;
  localparam int UNIT_COUNT_LSB    = 8;

  // Field widths.
  localparam int PIN_SEL_W   = 5;
  localparam int POR_TIME_W  = 7;
  localparam int PRESCALE_W  = 12;
  localparam int HOLD_W      = 5;
  localparam int GPIO_COUNT  = 32;

  // Values after reset.
  localparam logic [POR_TIME_W-1:0] POR_TIME_RST  = 7'h20;
  localparam logic [7:0]            REF_TRIM_RST  = 8'h80;
  localparam logic [7:0]            XTAL_TRIM_RST = 8'h00;
  localparam logic [31:0]           SCRATCH_RST   = 32'h00000000;

  // The qualification unit is 4096 RC periods of nominally 31.25 us.
  localparam int RC_PERIOD_PS      = 31250000;
  localparam int RC_TICKS_PER_UNIT = 4096;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 12'(RC_TICKS_PER_UNIT - 1);

  // Reset hold count, rounded up to whole mclk cycles; each pulse driven out lasts one cycle more.
  localparam int MCLK_PERIOD_NS = 100;
  localparam int RESET_HOLD_NS  = 1600;
  localparam logic [HOLD_W-1:0] RESET_HOLD_CYCLES =
    5'((RESET_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TMR_IDLE  = 2'b00,
    TMR_COUNT = 2'b01,
    TMR_FIRED = 2'b10
  } rsc_timer_state_type;

endpackage

// ==== verilog/rsc_sync2.sv ====
// Two-stage synchroniser for a bus of independent asynchronous levels.
// Assumes each bit is a level that holds for several mclk periods.
`timescale 1ns/10ps
module rsc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // rsc_sync2

// ==== test/rsc_far_model.sv ====
// Far side of the controller: the reset pad driver and the CPU reset request.
// Assumes calls are made just after a rising mclk edge.
`timescale 1ns/10ps
module rsc_far_model (
  input  wire logic mclk,
  output logic      reset_pad,
  output logic      cpu_reset_request
);
  // The pad has a pull-down, so an undriven pad reads low.
  initial reset_pad = 1'b0;
  initial cpu_reset_request = 1'b0;
  task automatic pad(input logic lv);
    @(posedge mclk);
    reset_pad <= lv;
  endtask
  task automatic cpu_req();
    @(posedge mclk);
    cpu_reset_request <= 1'b1;
    @(posedge mclk);
    cpu_reset_request <= 1'b0;
  endtask
endmodule // rsc_far_model

// ==== test/rsc_reset_checker_props.sv ====
// Checks the reset outputs and register groups of the controller.
// Bound to the controller; one clock domain.
`timescale 1ns/10ps
module rsc_reset_checker
  import rsc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       reset_pad,
  input wire logic       cpu_reset_request,
  input wire logic       por_reset,
  input wire logic       hw_reset,
  input wire logic       soft_reset_bit,
  input wire logic       cold_start,
  input wire logic       rc_osc_enable,
  input wire logic       rc_default_trim,
  input wire logic [7:0] reference_trim,
  input wire logic [7:0] crystal_trim,
  input wire logic [1:0] exchange_memory_map,
  input wire logic       debug_freeze_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  cold_sum_a: assert property (cold_start == (por_reset || hw_reset))
    else $error("cold start differs from por or hw reset");
  cpu_soft_a: assert property (cpu_reset_request |=> soft_reset_bit)
    else $error("cpu request gave no soft reset");
  soft_len_a: assert property ($rose(soft_reset_bit) |-> soft_reset_bit[*8] ##9 soft_reset_bit ##1 !soft_reset_bit)
    else $error("soft reset pulse length wrong");
  pad_trim_a: assert property (reset_pad[*4] |-> rc_default_trim)
    else $error("default trim not used for pad source");
  pad_idle_a: assert property (!reset_pad[*4] |-> !rc_default_trim)
    else $error("default trim while pad low");
  osc_on_a: assert property (reset_pad[*5] |-> rc_osc_enable)
    else $error("oscillator off while source active");
  cold_clear_a: assert property ($rose(cold_start) |=> crystal_trim == XTAL_TRIM_RST
    && exchange_memory_map == 2'h0 && !debug_freeze_enable)
    else $error("cold reset left a register set");
  trim_keep_a: assert property ((soft_reset_bit || hw_reset) && !por_reset
    |-> $stable(reference_trim))
    else $error("reference trim changed without power-on");
  cover property ($rose(por_reset));
  cover property ($rose(hw_reset));
  cover property ($rose(soft_reset_bit));
endmodule // rsc_reset_checker

bind rsc_reset_source_controller rsc_reset_checker u_chk (
  .mclk(mclk), .rst_n(rst_n), .reset_pad(reset_pad),
  .cpu_reset_request(cpu_reset_request), .por_reset(por_reset), .hw_reset(hw_reset),
  .soft_reset_bit(soft_reset_bit), .cold_start(cold_start), .rc_osc_enable(rc_osc_enable),
  .rc_default_trim(rc_default_trim), .reference_trim(reference_trim),
  .crystal_trim(crystal_trim), .exchange_memory_map(exchange_memory_map),
  .debug_freeze_enable(debug_freeze_enable));

// ==== test/test_reset_source_controller.sv ====
// Self-checking bench: AXI4-Lite register tasks plus pad, GPIO and CPU stimulus.
// Assumes rsc_pkg, the far-side model and the checker are compiled first.
`timescale 1ns/10ps
module test_reset_source_controller;
  import rsc_pkg::*;
  logic        mclk, rst_n, awv, wv, bready, arv, rready, rc, wake;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, pad, cpu, por, hw, sw, cold;
  logic [7:0]  awaddr, araddr, rtrim, xtrim;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata, gpio;
  logic [1:0]  bresp, rresp;
  logic [2:0]  rs;
  int          n_fail, comparisons, n;
  assign rs = {sw, hw, por};
  rsc_reset_source_controller u_dut (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reset_pad(pad), .gpio_in(gpio), .rc_clk_in(rc), .cpu_reset_request(cpu),
    .wake_from_sleep(wake), .por_reset(por), .hw_reset(hw), .soft_reset_bit(sw), .cold_start(cold),
    .rc_osc_enable(), .rc_default_trim(), .reference_trim(rtrim), .crystal_trim(xtrim),
    .exchange_memory_map(), .debug_freeze_enable());
  rsc_far_model u_far (.mclk(mclk), .reset_pad(pad), .cpu_reset_request(cpu));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // The RC clock runs far faster than in silicon to keep runs short: one delay unit of
  // 4096 RC edges then takes 16384 mclk cycles.
  initial begin
    rc = 1'b0;
    forever #200 rc = ~rc;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready and response are read mid-cycle, where they equal what the next edge samples.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    b = 1'b0;
    {awaddr, wdata, awv, wv, bready} <= {a, d, 3'b111};
    while (!b) begin
      @(negedge mclk);
      {ta, tw, b, r} = {awrdy, wrdy, bvalid, bresp};
      @(posedge mclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge mclk);
    chk(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, b;
    logic [31:0] d;
    logic [1:0] r;
    b = 1'b0;
    {araddr, arv, rready} <= {a, 2'b11};
    while (!b) begin
      @(negedge mclk);
      {ta, b, d, r} = {arrdy, rvalid, rdata, rresp};
      @(posedge mclk);
      if (ta) arv <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge mclk);
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask
  task automatic wt(input int k, input int lim);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rs[k] !== 1'b1 && n < lim);
    chk(32'(cold), 32'(k != 2));
    repeat (20) @(posedge mclk);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #6000000;
    n_fail++;
    test_done();
  end
  initial begin
    {rst_n, awv, wv, bready, arv, rready, wake, n_fail, comparisons} = '0;
    {awaddr, araddr, wdata, gpio, wstrb} = {48'h0, 32'hFFFFFFFF, 4'hF};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(ADDR_POR_TIMER, 32'h00000020, RESP_OKAY);
    rd(ADDR_REF_TRIM, 32'h00000080, RESP_OKAY);
    wr(ADDR_POR_TIMER, 32'h000000FF, RESP_OKAY);
    rd(ADDR_POR_TIMER, 32'h0000007F, RESP_OKAY);
    wr(8'h40, 32'h0000000F, RESP_SLVERR);
    rd(8'h40, 32'h00000000, RESP_SLVERR);
    wr(ADDR_REF_TRIM, 32'h0000005A, RESP_OKAY);
    wr(ADDR_XTAL_TRIM, 32'h00000033, RESP_OKAY);
    wr(ADDR_SCRATCH, 32'hDEADBEEF, RESP_OKAY);
    wstrb <= 4'h3;
    wr(ADDR_SCRATCH, 32'h12345678, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_SCRATCH, 32'hDEAD5678, RESP_OKAY);
    wr(ADDR_POR_PIN, 32'h00000105, RESP_OKAY);
    wr(ADDR_SYS_CTRL, 32'h00000001, RESP_OKAY);
    wt(2, 10);
    chk(32'(n <= 2), 32'h00000001);
    rd(ADDR_SCRATCH, 32'h00000000, RESP_OKAY);
    rd(ADDR_POR_PIN, 32'h00000100, RESP_OKAY);
    rd(ADDR_XTAL_TRIM, 32'h00000033, RESP_OKAY);
    u_far.cpu_req();
    wt(2, 10);
    chk(32'(n <= 2), 32'h00000001);
    wr(ADDR_PWR_CTRL, 32'h00000001, RESP_OKAY);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    wt(1, 10);
    chk(32'(n <= 3), 32'h00000001);
    rd(ADDR_PWR_CTRL, 32'h00000000, RESP_OKAY);
    rd(ADDR_XTAL_TRIM, 32'h00000000, RESP_OKAY);
    chk(32'(xtrim), 32'h00000000);
    wr(ADDR_GEN_CTRL, 32'h00000013, RESP_OKAY);
    wr(ADDR_POR_TIMER, 32'h00000001, RESP_OKAY);
    u_far.pad(1'b1);
    repeat (100) @(posedge mclk);
    u_far.pad(1'b0);
    wt(1, 30);
    chk(32'(n < 30 && por === 1'b0), 32'h00000001);
    rd(ADDR_GEN_CTRL, 32'h00000000, RESP_OKAY);
    rd(ADDR_REF_TRIM, 32'h0000005A, RESP_OKAY);
    u_far.pad(1'b1);
    wt(0, 17000);
    chk(32'(n >= 16380 && n <= 16400), 32'h00000001);
    u_far.pad(1'b0);
    rd(ADDR_REF_TRIM, 32'h00000080, RESP_OKAY);
    chk(32'(rtrim), 32'h00000080);
    rd(ADDR_POR_TIMER, 32'h00000020, RESP_OKAY);
    wr(ADDR_POR_TIMER, 32'h00000001, RESP_OKAY);
    wr(ADDR_POR_PIN, 32'h00000003, RESP_OKAY);
    gpio <= 32'hFFFFFFF7;
    repeat (8000) @(posedge mclk);
    u_far.pad(1'b1);
    repeat (100) @(posedge mclk);
    gpio <= 32'hFFFFFFFF;
    wt(0, 9000);
    chk(32'(n > 8200 && n < 8380), 32'h00000001);
    u_far.pad(1'b0);
    test_done();
  end
endmodule // test_reset_source_controller
